// File: src/erae_pkg.sv
/*
 * shared constants and carrier types of the ethernet register access engine.
 * assumes a 200 MHz core clock and byte-wide frame streams without fcs.
 */
`default_nettype none
package erae_pkg;
	// frame identification
	localparam logic [15:0] ETYPE_RRAP = 16'h8880; // protocol ethertype
	localparam logic [15:0] PROTO_ID = 16'h0004; // protocol identifier
	localparam logic [15:0] ETYPE_VLAN = 16'h8100; // single vlan tag
	localparam logic [31:0] ID_WORD = {ETYPE_RRAP, PROTO_ID}; // both fields
	// word positions inside a received frame
	localparam logic [8:0] WIX_SMAC_HI = 9'h001; // dmac low / smac high
	localparam logic [8:0] WIX_SMAC_LO = 9'h002; // smac low
	localparam logic [8:0] WIX_TYPE = 9'h003; // tag or identification
	localparam logic [8:0] WIX_HDR = 9'h004; // header when untagged
	localparam logic [9:0] HDR_WORDS = 10'h005; // response words before data
	// protocol header layout
	localparam int HDR_VER_LSB = 28; // version in bits 31..28
	localparam int HDR_FLAG_R = 24; // response flag bit
	localparam logic [3:0] HDR_VERSION = 4'h1; // supported version
	localparam logic REQ_FLAG_R = 1'b1; // flag value a request must carry
	localparam logic [31:0] RSP_HDR = 32'h1100_0000; // ver 1, r=1, zeros
	// command codes
	localparam logic [3:0] CMD_IDLE = 4'h0; // low nibble of idle
	localparam logic [3:0] CMD_PAUSE = 4'h4; // low nibble of pause
	localparam logic [1:0] CMD_READ = 2'b01; // low bits of read
	localparam logic [1:0] CMD_WRITE = 2'b10; // low bits of write
	localparam logic [1:0] CMD_RMW = 2'b11; // low bits of rmw
	// response frame sizing
	localparam int MIN_FRAME_BYTES = 60; // minimum frame without fcs
	localparam logic [9:0] MIN_WORDS = 10'(MIN_FRAME_BYTES / 4);
	localparam int MEM_AW = 9; // response store address width
	localparam logic [9:0] MEM_DEPTH = 10'h200; // response store words
	// pause timing
	localparam int CLK_PERIOD_NS = 5; // core clock period
	localparam int PAUSE_UNIT_NS = 1000; // pause unit of 1 us
	localparam int US_CYCLES = PAUSE_UNIT_NS / CLK_PERIOD_NS;
	localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1); // divider wrap
	// reset values
	localparam logic [47:0] OWN_MAC_DEFAULT = 48'h0200_0000_0001; // arbitrary
	// one byte of a frame stream
	typedef struct packed {
		logic sof; // first byte of frame
		logic eof; // last byte of frame
		logic [7:0] data; // byte value
	} erae_byte_t;
	// one register access request
	typedef struct packed {
		logic we; // write when set
		logic [31:0] addr; // aligned byte address
		logic [31:0] wdata; // write data
	} erae_regcmd_t;
endpackage
`default_nettype wire

// File: src/erae_word_pack.sv
/*
 * gathers frame bytes into 32-bit words, first byte most significant.
 * assumes take is only high for bytes that the engine accepts.
 */
`timescale 1ns/100ps
`default_nettype none
module erae_word_pack (
	input wire logic clk, // core clock
	input wire logic nrst, // sync reset, active low
	input wire logic take, // byte accepted this cycle
	input wire erae_pkg::erae_byte_t in_byte, // accepted byte
	output logic [1:0] pos_ff, // bytes held of current word
	output logic [31:0] word_ff, // completed word
	output logic word_vld_ff, // one-cycle pulse per word
	output logic [8:0] word_ix_ff // word number inside frame
);
	import erae_pkg::*;
	logic [23:0] acc_ff; // partial word
	logic [8:0] cnt_ff; // words completed so far
	logic [1:0] eff_pos; // position, restarted by sof
	logic done; // this byte closes a word

	assign eff_pos = in_byte.sof ? 2'd0 : pos_ff;
	assign done = take && (eff_pos == 2'd3);

	// byte position and shift register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pos_ff <= 2'd0;
			acc_ff <= 24'h0;
		end else if (take) begin
			pos_ff <= eff_pos + 2'd1;
			acc_ff <= {acc_ff[15:0], in_byte.data};
		end
	end

	// completed word, most significant byte first
	always_ff @(posedge clk) begin
		if (!nrst) begin
			word_ff <= 32'h0;
			word_vld_ff <= 1'b0;
			word_ix_ff <= 9'h0;
			cnt_ff <= 9'h0;
		end else begin
			word_vld_ff <= done;
			if (take && in_byte.sof)
				cnt_ff <= 9'h0;
			if (done) begin
				word_ff <= {acc_ff, in_byte.data};
				word_ix_ff <= cnt_ff;
				if (cnt_ff != 9'h1ff)
					cnt_ff <= cnt_ff + 9'h1;
			end
		end
	end
endmodule
`default_nettype wire

// File: src/erae_resp_mem.sv
/*
 * response data store: one write port, one read port with registered data.
 * assumes the reader waits one cycle after presenting an address.
 */
`timescale 1ns/100ps
`default_nettype none
module erae_resp_mem (
	input wire logic clk, // core clock
	input wire logic we, // write strobe
	input wire logic [erae_pkg::MEM_AW-1:0] waddr, // write address
	input wire logic [31:0] wdata, // write data
	input wire logic [erae_pkg::MEM_AW-1:0] raddr, // read address
	output logic [31:0] rdata_ff // read data, one cycle late
);
	import erae_pkg::*;
	logic [31:0] mem [0:(1<<MEM_AW)-1]; // storage

	// write and registered read
	always_ff @(posedge clk) begin
		if (we)
			mem[waddr] <= wdata;
		rdata_ff <= mem[raddr];
	end
endmodule
`default_nettype wire

// File: src/erae_engine.sv
/*
 * ethernet register access engine: parses request frames, runs their
 * commands on the internal register bus and streams back a response frame.
 * assumes byte streams without preamble or fcs and a register bus slave
 * that answers every request with a one-cycle ack.
 */
`timescale 1ns/100ps
`default_nettype none
module erae_engine #(
	parameter logic [47:0] OWN_MAC = erae_pkg::OWN_MAC_DEFAULT // own address
) (
	input wire logic clk, // core clock, 200 MHz
	input wire logic nrst, // sync reset, active low
	input wire erae_pkg::erae_byte_t rx_byte, // request stream byte
	input wire logic rx_valid, // rx_byte is valid
	output logic rx_ready, // engine takes rx_byte
	output erae_pkg::erae_byte_t tx_byte, // response stream byte
	output logic tx_valid, // tx_byte is valid
	input wire logic tx_ready, // sink takes tx_byte
	output logic reg_req, // register request pending
	output erae_pkg::erae_regcmd_t reg_cmd, // register request
	input wire logic reg_ack, // one-cycle answer
	input wire logic [31:0] reg_rdata // read data with ack
);
	import erae_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE, ST_PARSE, ST_SKIP, ST_CMD, ST_WDATA, ST_RMWD, ST_RMWM,
		ST_RD, ST_WR, ST_RMWR, ST_RMWW, ST_PAUSE, ST_STOP,
		ST_TXF, ST_TXL, ST_TXB
	} erae_state_t;

	erae_state_t state_ff, nxt_state; // engine state
	logic take; // request byte accepted
	logic [1:0] pos; // packer byte position
	logic eff3; // accepted byte closes a word
	logic [31:0] word; // completed request word
	logic word_vld; // word pulse
	logic [8:0] word_ix; // word number
	logic rx_ready_ff; // ready register
	logic eof_ff; // last byte of frame seen
	logic tagged_ff; // request carried a vlan tag
	logic [15:0] tci_ff; // request tag control
	logic [47:0] smac_ff; // requester address
	logic [31:0] addr_ff; // command address
	logic [31:0] wd_ff; // rmw write data
	logic [31:0] mask_ff; // rmw mask
	logic [27:0] pause_cnt_ff; // microseconds left
	logic [7:0] us_div_ff; // cycles inside a microsecond
	logic us_tick; // one-cycle microsecond enable
	logic [9:0] nresp_ff; // response data words stored
	logic mem_we; // store a response word
	logic [31:0] mem_wdata; // word to store
	logic [31:0] mem_rdata; // stored word read back
	logic [9:0] hw; // response header words
	logic [9:0] rsp_end; // end of response data
	logic [9:0] tx_total; // response length in words
	logic [9:0] tw_ff; // response word being sent
	logic [1:0] bix_ff; // byte of that word
	logic [31:0] tx_word_ff; // word shifting out
	logic [31:0] tx_comp; // composed response word
	logic tx_valid_ff; // tx valid register
	erae_byte_t tx_byte_ff; // tx byte register
	logic reg_req_ff; // request register
	erae_regcmd_t reg_cmd_ff; // request contents
	logic is_idle, is_pause, is_rd, is_wr, is_rmw, is_bad; // decode
	logic id_ok, hdr_ok, is_tag; // identification checks
	logic [8:0] hdr_ix; // word number of header
	logic [31:0] merged; // rmw result

	assign take = rx_valid && rx_ready_ff;
	assign eff3 = take && !rx_byte.sof && (pos == 2'd3);

	erae_word_pack u_pack (
		.clk(clk),
		.nrst(nrst),
		.take(take),
		.in_byte(rx_byte),
		.pos_ff(pos),
		.word_ff(word),
		.word_vld_ff(word_vld),
		.word_ix_ff(word_ix)
	);

	// command decode on the low bits of a word
	assign is_idle = (word[3:0] == CMD_IDLE);
	assign is_pause = (word[3:0] == CMD_PAUSE);
	assign is_rd = (word[1:0] == CMD_READ);
	assign is_wr = (word[1:0] == CMD_WRITE);
	assign is_rmw = (word[1:0] == CMD_RMW);
	assign is_bad = !(is_idle || is_pause || is_rd || is_wr || is_rmw);

	// identification and header checks
	assign id_ok = (word == ID_WORD);
	assign is_tag = (word[31:16] == ETYPE_VLAN);
	assign hdr_ix = tagged_ff ? WIX_HDR + 9'h1 : WIX_HDR;
	// spare flags and reserved bits are not looked at
	assign hdr_ok = (word[HDR_VER_LSB+:4] == HDR_VERSION)
		&& (word[HDR_FLAG_R] == REQ_FLAG_R);
	assign merged = (reg_rdata & ~mask_ff) | (wd_ff & mask_ff);

	// next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take && rx_byte.sof)
					nxt_state = ST_PARSE;
			end
			ST_PARSE: begin
				if (word_vld) begin
					if (word_ix == WIX_TYPE && !is_tag && !id_ok)
						nxt_state = ST_SKIP;
					else if (tagged_ff && word_ix == WIX_HDR && !id_ok)
						nxt_state = ST_SKIP;
					else if (word_ix == hdr_ix)
						nxt_state = hdr_ok ? ST_CMD : ST_SKIP;
				end else if (eof_ff) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_SKIP: begin
				if (eof_ff)
					nxt_state = ST_IDLE;
			end
			ST_CMD: begin
				// one command at a time, in frame order
				if (word_vld) begin
					if (is_idle)
						nxt_state = ST_CMD;
					else if (is_pause)
						nxt_state = ST_PAUSE;
					else if (is_rd)
						nxt_state = ST_RD;
					else if (is_wr)
						nxt_state = ST_WDATA;
					else if (is_rmw)
						nxt_state = ST_RMWD;
					else
						nxt_state = ST_STOP;
				end else if (eof_ff) begin
					nxt_state = ST_TXF;
				end
			end
			ST_WDATA: begin
				if (word_vld)
					nxt_state = ST_WR;
				else if (eof_ff)
					nxt_state = ST_TXF;
			end
			ST_RMWD: begin
				if (word_vld)
					nxt_state = ST_RMWM;
				else if (eof_ff)
					nxt_state = ST_TXF;
			end
			ST_RMWM: begin
				if (word_vld)
					nxt_state = ST_RMWR;
				else if (eof_ff)
					nxt_state = ST_TXF;
			end
			ST_RD, ST_WR, ST_RMWW: begin
				if (reg_ack)
					nxt_state = ST_CMD;
			end
			ST_RMWR: begin
				if (reg_ack)
					nxt_state = ST_RMWW;
			end
			ST_PAUSE: begin
				if (pause_cnt_ff == 28'h0)
					nxt_state = ST_CMD;
			end
			ST_STOP: begin
				if (eof_ff)
					nxt_state = ST_TXF;
			end
			ST_TXF: nxt_state = ST_TXL;
			ST_TXL: nxt_state = ST_TXB;
			ST_TXB: begin
				if (tx_valid_ff && tx_ready && bix_ff == 2'd3)
					nxt_state = (tw_ff == tx_total - 10'h1) ? ST_IDLE : ST_TXF;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (!nrst)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// end-of-frame flag, held until the frame is finished
	always_ff @(posedge clk) begin
		if (!nrst)
			eof_ff <= 1'b0;
		else if (take && rx_byte.sof)
			eof_ff <= rx_byte.eof;
		else if (take && rx_byte.eof && state_ff != ST_IDLE)
			eof_ff <= 1'b1;
		else if (nxt_state == ST_IDLE || nxt_state == ST_TXF)
			eof_ff <= 1'b0;
	end

	// ready: stalls while a word is decoded, a command runs or a reply goes
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_ready_ff <= 1'b0;
		end else begin
			case (nxt_state)
				ST_IDLE, ST_PARSE, ST_SKIP, ST_CMD, ST_WDATA, ST_RMWD,
				ST_RMWM, ST_STOP:
					rx_ready_ff <= !eff3 && !(take && rx_byte.eof)
						&& !(eof_ff && nxt_state != ST_IDLE);
				default: rx_ready_ff <= 1'b0;
			endcase
		end
	end

	// requester address and tag
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tagged_ff <= 1'b0;
			tci_ff <= 16'h0;
			smac_ff <= 48'h0;
		end else if (state_ff == ST_IDLE && take && rx_byte.sof) begin
			tagged_ff <= 1'b0;
		end else if (state_ff == ST_PARSE && word_vld) begin
			if (word_ix == WIX_SMAC_HI)
				smac_ff[47:32] <= word[15:0];
			if (word_ix == WIX_SMAC_LO)
				smac_ff[31:0] <= word;
			if (word_ix == WIX_TYPE && is_tag) begin
				tagged_ff <= 1'b1;
				tci_ff <= word[15:0];
			end
		end
	end

	// command operands
	always_ff @(posedge clk) begin
		if (!nrst) begin
			addr_ff <= 32'h0;
			wd_ff <= 32'h0;
			mask_ff <= 32'h0;
		end else if (word_vld) begin
			if (state_ff == ST_CMD)
				addr_ff <= {word[31:2], 2'b00};
			if (state_ff == ST_RMWD)
				wd_ff <= word;
			if (state_ff == ST_RMWM)
				mask_ff <= word;
		end
	end

	// register bus master
	always_ff @(posedge clk) begin
		if (!nrst) begin
			reg_req_ff <= 1'b0;
			reg_cmd_ff <= '0;
		end else begin
			case (state_ff)
				ST_CMD: if (word_vld && is_rd && !is_pause && !is_idle) begin
					reg_req_ff <= 1'b1;
					reg_cmd_ff <= '{1'b0, {word[31:2], 2'b00}, 32'h0};
				end
				ST_WDATA: if (word_vld) begin
					reg_req_ff <= 1'b1;
					reg_cmd_ff <= '{1'b1, addr_ff, word};
				end
				ST_RMWM: if (word_vld) begin
					reg_req_ff <= 1'b1;
					reg_cmd_ff <= '{1'b0, addr_ff, 32'h0};
				end
				ST_RMWR: if (reg_ack) begin
					reg_cmd_ff <= '{1'b1, addr_ff, merged};
				end
				ST_RD, ST_WR, ST_RMWW: if (reg_ack) begin
					reg_req_ff <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	// pause timer with microsecond enable from a divider
	assign us_tick = (state_ff == ST_PAUSE) && (us_div_ff == US_LAST);
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pause_cnt_ff <= 28'h0;
			us_div_ff <= 8'h0;
		end else if (state_ff == ST_CMD && word_vld && is_pause) begin
			pause_cnt_ff <= word[31:4];
			us_div_ff <= 8'h0;
		end else if (state_ff == ST_PAUSE) begin
			us_div_ff <= us_tick ? 8'h0 : us_div_ff + 8'h1;
			if (us_tick)
				pause_cnt_ff <= pause_cnt_ff - 28'h1;
		end
	end

	// response data store: read data and idle words in command order
	assign mem_we = (nresp_ff != MEM_DEPTH) && (((state_ff == ST_RD) &&
		reg_ack) || ((state_ff == ST_CMD) && word_vld && is_idle));
	assign mem_wdata = (state_ff == ST_RD) ? reg_rdata : word;
	always_ff @(posedge clk) begin
		if (!nrst)
			nresp_ff <= 10'h0;
		else if (state_ff == ST_IDLE && take && rx_byte.sof)
			nresp_ff <= 10'h0;
		else if (mem_we)
			nresp_ff <= nresp_ff + 10'h1;
	end

	erae_resp_mem u_mem (
		.clk(clk),
		.we(mem_we),
		.waddr(nresp_ff[MEM_AW-1:0]),
		.wdata(mem_wdata),
		.raddr(9'(tw_ff - hw)),
		.rdata_ff(mem_rdata)
	);

	// response length, padded to the minimum frame
	assign hw = tagged_ff ? HDR_WORDS + 10'h1 : HDR_WORDS;
	assign rsp_end = hw + nresp_ff;
	assign tx_total = (rsp_end < MIN_WORDS) ? MIN_WORDS : rsp_end;

	// response word for the current position
	always_comb begin
		tx_comp = 32'h0;
		if (tw_ff < hw) begin
			case (tw_ff[2:0])
				3'd0: tx_comp = smac_ff[47:16];
				3'd1: tx_comp = {smac_ff[15:0], OWN_MAC[47:32]};
				3'd2: tx_comp = OWN_MAC[31:0];
				3'd3: tx_comp = tagged_ff ? {ETYPE_VLAN, tci_ff} : ID_WORD;
				3'd4: tx_comp = tagged_ff ? ID_WORD : RSP_HDR;
				default: tx_comp = RSP_HDR;
			endcase
		end else if (tw_ff < rsp_end) begin
			tx_comp = mem_rdata;
		end
	end

	// response byte stream, most significant byte first
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tx_valid_ff <= 1'b0;
			tx_byte_ff <= '0;
			tx_word_ff <= 32'h0;
			bix_ff <= 2'd0;
			tw_ff <= 10'h0;
		end else begin
			case (state_ff)
				ST_TXF: ;
				ST_TXL: begin
					tx_word_ff <= tx_comp;
					tx_valid_ff <= 1'b1;
					tx_byte_ff <= '{tw_ff == 10'h0, 1'b0, tx_comp[31:24]};
					bix_ff <= 2'd0;
				end
				ST_TXB: if (tx_valid_ff && tx_ready) begin
					if (bix_ff == 2'd3) begin
						tx_valid_ff <= 1'b0;
						tw_ff <= tw_ff + 10'h1;
					end else begin
						bix_ff <= bix_ff + 2'd1;
						tx_word_ff <= {tx_word_ff[23:0], 8'h00};
						tx_byte_ff <= '{1'b0, (tw_ff == tx_total - 10'h1) &&
							(bix_ff == 2'd2), tx_word_ff[23:16]};
					end
				end
				default: tw_ff <= 10'h0;
			endcase
		end
	end

	assign rx_ready = rx_ready_ff;
	assign tx_byte = tx_byte_ff;
	assign tx_valid = tx_valid_ff;
	assign reg_req = reg_req_ff;
	assign reg_cmd = reg_cmd_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_rmw_read;
		(state_ff == ST_RMWR) && reg_ack;
	endsequence
	sequence s_bad_cmd;
		(state_ff == ST_CMD) && word_vld && is_bad;
	endsequence

	property p_read_issue;
		(state_ff == ST_CMD) && word_vld && is_rd |=> reg_req_ff &&
			!reg_cmd_ff.we && reg_cmd_ff.addr == {$past(word[31:2]), 2'b00};
	endproperty
	a_read_issue: assert property (p_read_issue) else $error("read not issued");
	property p_write_issue;
		(state_ff == ST_WDATA) && word_vld |=> reg_req_ff && reg_cmd_ff.we
			&& reg_cmd_ff.wdata == $past(word);
	endproperty
	a_write_issue: assert property (p_write_issue) else $error("bad write");
	property p_rmw_merge;
		s_rmw_read |=> reg_req_ff && reg_cmd_ff.we && reg_cmd_ff.wdata ==
			(($past(reg_rdata) & ~mask_ff) | (wd_ff & mask_ff));
	endproperty
	a_rmw_merge: assert property (p_rmw_merge) else $error("bad rmw merge");
	property p_idle_copy;
		(state_ff == ST_CMD) && word_vld && is_idle && nresp_ff != MEM_DEPTH
			|-> mem_we && mem_wdata == word;
	endproperty
	a_idle_copy: assert property (p_idle_copy) else $error("idle not kept");
	property p_pause_quiet;
		(state_ff == ST_PAUSE) && pause_cnt_ff != 28'h0 |=> !reg_req_ff &&
			state_ff == ST_PAUSE;
	endproperty
	a_pause_quiet: assert property (p_pause_quiet) else $error("pause cut");
	property p_bad_hdr;
		(state_ff == ST_PARSE) && word_vld && word_ix == hdr_ix && !hdr_ok
			&& tagged_ff == 1'b0 |=> state_ff == ST_SKIP ##1 !reg_req_ff;
	endproperty
	a_bad_hdr: assert property (p_bad_hdr) else $error("bad header ran");
	property p_pad;
		tx_valid_ff && tx_byte_ff.eof |-> tw_ff >= MIN_WORDS - 10'h1;
	endproperty
	a_pad: assert property (p_pad) else $error("response too short");
	property p_bad_stop;
		s_bad_cmd |=> state_ff == ST_STOP;
	endproperty
	a_bad_stop: assert property (p_bad_stop) else $error("unknown cmd ran");
	property p_us_tick;
		(state_ff == ST_PAUSE) && us_tick |=>
			pause_cnt_ff == $past(pause_cnt_ff) - 28'h1;
	endproperty
	a_us_tick: assert property (p_us_tick) else $error("pause count off");
endmodule
`default_nettype wire

// File: verification/erae_reg_model.sv
/*
 * register space model behind the engine's register bus.
 * assumes one request at a time, held with its command until the ack.
 */
`timescale 1ns/100ps
`default_nettype none
module erae_reg_model (
	input wire logic clk, // core clock
	input wire erae_pkg::erae_regcmd_t reg_cmd, // request command
	input wire logic reg_req, // request pending
	output logic reg_ack, // one-cycle answer
	output logic [31:0] reg_rdata // read data in the ack cycle
);
	import erae_pkg::*;
	logic [31:0] regs_ff [16]; // sixteen register words, start at zero
	logic [1:0] wait_ff; // cycles waited on this request
	logic slow_ff; // alternates prompt and slow answers
	logic [31:0] last_addr_ff; // full address of the last answered request
	initial begin
		foreach (regs_ff[i]) regs_ff[i] = 32'h0;
		last_addr_ff = 32'h0;
		wait_ff = 2'h0;
		slow_ff = 1'b0;
		reg_ack = 1'b0;
		reg_rdata = 32'h0;
	end
	// answer after one or three cycles; data is scrambled outside the ack
	always @(posedge clk) begin
		reg_ack <= 1'b0;
		reg_rdata <= ~reg_rdata;
		// a request still high right after an ack is not served in that cycle
		if (reg_req && !reg_ack) begin
			if (wait_ff == {slow_ff, 1'b0}) begin
				reg_ack <= 1'b1;
				wait_ff <= 2'h0;
				slow_ff <= !slow_ff;
				reg_rdata <= regs_ff[reg_cmd.addr[5:2]];
				// kept whole so the bench sees every address bit
				last_addr_ff <= reg_cmd.addr;
				if (reg_cmd.we) regs_ff[reg_cmd.addr[5:2]] <= reg_cmd.wdata;
			end else begin
				wait_ff <= wait_ff + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// File: verification/erae_engine_test.sv
/*
 * self-checking bench of the register access engine: a station sends
 * request frames, the register model answers, responses are compared.
 * assumes the engine's default own address and a 200 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module erae_engine_test;
	import erae_pkg::*;
	localparam logic [47:0] STA_MAC = 48'h0a00_0000_0099; // station address
	logic clk = 1'b0; // core clock
	logic nrst = 1'b0; // reset, held low first
	erae_byte_t rx_byte = '0; // request byte
	logic rx_valid = 1'b0; // request byte valid
	logic tx_ready = 1'b1; // response sink ready
	logic slow = 1'b0; // sink stalls when set
	logic rx_ready, tx_valid, reg_req, reg_ack; // design handshakes
	erae_byte_t tx_byte; // response byte
	erae_regcmd_t reg_cmd; // register command
	logic [31:0] reg_rdata; // register read data
	int err_count = 0; // mismatches
	int checks = 0; // comparisons made
	int cyc = 0; // cycle counter
	int ack_cyc[$]; // cycles of register answers
	logic [31:0] rq[$]; // request words
	logic [31:0] eq[$]; // expected response words
	always #2.5 clk = ~clk;
	// cycle count, sink pacing and register answer log
	always @(posedge clk) begin
		cyc <= cyc + 1;
		tx_ready <= !slow || cyc[1];
		if (reg_ack === 1'b1) ack_cyc.push_back(cyc);
	end
	erae_engine u_erae_engine (.clk(clk), .nrst(nrst), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_byte(tx_byte),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .reg_req(reg_req),
		.reg_cmd(reg_cmd), .reg_ack(reg_ack), .reg_rdata(reg_rdata));
	erae_reg_model u_erae_reg_model (.clk(clk), .reg_cmd(reg_cmd),
		.reg_req(reg_req), .reg_ack(reg_ack), .reg_rdata(reg_rdata));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (err_count == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// frame head of request and expected response; tag zero is untagged
	task automatic frame(input logic [15:0] tag, input logic [31:0] idw,
		input logic [31:0] hw);
		rq = {};
		eq = {};
		rq.push_back(OWN_MAC_DEFAULT[47:16]);
		rq.push_back({OWN_MAC_DEFAULT[15:0], STA_MAC[47:32]});
		rq.push_back(STA_MAC[31:0]);
		eq.push_back(STA_MAC[47:16]);
		eq.push_back({STA_MAC[15:0], OWN_MAC_DEFAULT[47:32]});
		eq.push_back(OWN_MAC_DEFAULT[31:0]);
		if (tag != 16'h0) begin
			rq.push_back({ETYPE_VLAN, tag});
			eq.push_back({ETYPE_VLAN, tag});
		end
		rq.push_back(idw);
		rq.push_back(hw);
		eq.push_back(32'h8880_0004);
		eq.push_back(32'h1100_0000);
	endtask
	// send rq, most significant byte first, holding each byte until taken
	task automatic send();
		int n;
		n = rq.size() * 4;
		@(posedge clk);
		for (int i = 0; i < n; i++) begin
			rx_byte <= {1'(i == 0), 1'(i == n - 1), rq[i/4][31-8*(i%4) -: 8]};
			rx_valid <= 1'b1;
			@(negedge clk);
			for (int w = 0; w < 5000 && rx_ready !== 1'b1; w++) @(negedge clk);
			@(posedge clk);
		end
		rx_valid <= 1'b0;
	endtask
	// collect one response frame and compare it with eq after padding
	task automatic recv();
		logic [7:0] b[$];
		while (eq.size() < MIN_FRAME_BYTES / 4) eq.push_back(32'h0);
		for (int w = 0; w < 20000; w++) begin
			@(negedge clk);
			if (tx_valid === 1'b1 && tx_ready) begin
				chk(32'(tx_byte.sof), 32'(b.size() == 0));
				b.push_back(tx_byte.data);
				if (tx_byte.eof !== 1'b0) break;
			end
		end
		chk(b.size(), eq.size() * 4);
		foreach (b[i]) chk(b[i], eq[i/4][31-8*(i%4) -: 8]);
	endtask
	// write, read, idle, rmw, read in one untagged frame
	task automatic t_basic();
		frame(16'h0, 32'h8880_0004, 32'h1100_0000);
		rq.push_back(32'hfedc_ba0e); // write to word 3
		rq.push_back(32'ha5a5_1234);
		rq.push_back(32'hfedc_ba0d); // read word 3
		rq.push_back(32'h1234_5670); // idle with station code
		rq.push_back(32'hfedc_ba0f); // rmw word 3
		rq.push_back(32'h0000_ffff);
		rq.push_back(32'h00ff_00ff);
		rq.push_back(32'hfedc_ba0d);
		eq.push_back(32'ha5a5_1234);
		eq.push_back(32'h1234_5670);
		eq.push_back(32'ha500_12ff);
		send();
		recv();
		chk(u_erae_reg_model.regs_ff[3], 32'ha500_12ff);
		chk(u_erae_reg_model.last_addr_ff, 32'hfedc_ba0c);
	endtask
	// tagged request with spare flags and reserved bits set, sink stalling
	task automatic t_tagged();
		slow = 1'b1;
		frame(16'h0123, 32'h8880_0004, 32'h1f00_abcd);
		rq.push_back(32'h0123_458d);
		rq.push_back(32'h0000_0010);
		eq.push_back(32'ha500_12ff);
		eq.push_back(32'h0000_0010);
		send();
		recv();
		chk(u_erae_reg_model.last_addr_ff, 32'h0123_458c);
		slow = 1'b0;
	endtask
	// broken identifier, ethertype, version or request flag: no response
	task automatic t_drop();
		logic [31:0] bid[4] = '{32'h8880_0005, 32'h8881_0004,
			32'h8880_0004, 32'h8880_0004};
		logic [31:0] bhd[4] = '{32'h1100_0000, 32'h1100_0000,
			32'h2100_0000, 32'h1000_0000};
		int seen;
		for (int k = 0; k < 4; k++) begin
			seen = 0;
			frame(16'h0, bid[k], bhd[k]);
			rq.push_back(32'h0000_0016);
			rq.push_back(32'hffff_ffff);
			send();
			repeat (300) @(negedge clk) if (tx_valid !== 1'b0) seen++;
			chk(seen, 0);
		end
		chk(u_erae_reg_model.regs_ff[5], 32'h0);
	endtask
	// two microsecond pause between two writes
	task automatic t_pause();
		int d;
		frame(16'h0, 32'h8880_0004, 32'h1100_0000);
		rq.push_back(32'h0000_001e);
		rq.push_back(32'h0000_0001);
		rq.push_back(32'h0000_0024); // pause of 2 units
		rq.push_back(32'h0000_001e);
		rq.push_back(32'h0000_0002);
		ack_cyc = {};
		send();
		recv();
		chk(ack_cyc.size(), 2);
		d = ack_cyc.size() == 2 ? ack_cyc[1] - ack_cyc[0] : 0;
		chk(32'(d >= 2 * US_CYCLES && d < 2 * US_CYCLES + 60), 1);
		chk(u_erae_reg_model.regs_ff[7], 32'h2);
	endtask
	// undefined command ends the frame's processing
	task automatic t_unknown();
		frame(16'h0, 32'h8880_0004, 32'h1100_0000);
		rq.push_back(32'h7f00_004d);
		rq.push_back(32'h0000_0008);
		rq.push_back(32'h0000_001a);
		rq.push_back(32'h0000_0077);
		eq.push_back(32'ha500_12ff);
		send();
		recv();
		chk(u_erae_reg_model.regs_ff[6], 32'h0);
		chk(u_erae_reg_model.last_addr_ff, 32'h7f00_004c);
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_basic();
		t_tagged();
		t_drop();
		t_pause();
		t_unknown();
		conclude();
	end
	// watchdog: all tests take far fewer than 20000 cycles
	initial begin
		#100000;
		err_count++;
		conclude();
	end
endmodule
`default_nettype wire
